// ===== core/gpw_pkg.sv
// Shared constants, pin map and bus carrier for the GPIO wake/SMI port block.
// Assumes a 48-slot pin space: slot = (port - 1) * 8 + bit for ports one to six.
package gpw_pkg;

  // Sizes of the pin space and of the event register banks.
  localparam int NPIN = 48;
  localparam int NPORT = 6;
  localparam int NWAKE = 32;
  localparam int NSMI = 24;
  localparam int NMISC = 6;

  // Register offsets from the runtime block base.
  localparam logic [7:0] OFS_DATA_BASE = 8'h4B;
  localparam logic [7:0] OFS_CFG_BASE = 8'h80;
  localparam logic [7:0] OFS_WAKE_STS = 8'h10;
  localparam logic [7:0] OFS_WAKE_EN = 8'h14;
  localparam logic [7:0] OFS_WAKE_GLB = 8'h18;
  localparam logic [7:0] OFS_SMI_STS = 8'h20;
  localparam logic [7:0] OFS_SMI_EN = 8'h23;
  localparam logic [7:0] OFS_MISC_STS = 8'h26;

  // Configuration register field positions.
  localparam int CFG_DIR = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_EITHER_EDGE_IRQ = 2;
  localparam int CFG_ALT = 3;
  localparam int CFG_OD = 7;
  localparam int GLB_EN_BIT = 0;

  // Reset values.
  localparam logic [7:0] CFG_RST_IN = 8'h01;
  localparam logic [7:0] CFG_RST_OUT_LOW = 8'h00;
  localparam logic [47:0] PAD_OE_N_RST = 48'hFFF7_FFF3_FFFF;

  // Pin slots with special behaviour.
  localparam logic [7:0] PIN_NONE = 8'hFF;
  localparam logic [7:0] PIN_TACH1 = 8'hF0;
  localparam logic [7:0] PIN_TACH2 = 8'hF1;
  localparam int PIN_KBC_A = 10;
  localparam int PIN_SMI_OUT = 15;
  localparam int PIN_DRIVE_RATE = 27;
  localparam int PIN_JOY_LO = 4;
  localparam int PIN_JOY_HI = 7;

  // Register bus request carrier.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } gpw_bus_req_t;

  // Pin slot behind each wake status bit (bank 2 bit 0 is slot 0).
  function automatic logic [7:0] wake_pin(input int s);
    if (s < 8) return 8'(s);
    if (s < 16) return (s == 11) ? PIN_NONE : 8'(s);
    if (s < 20) return 8'(s);
    case (s)
      20: return 8'd25;
      21: return 8'd27;
      22: return 8'd40;
      23: return 8'd41;
      default: return 8'(s + 8);
    endcase
  endfunction

  // Pin slot behind each SMI status bit (bank 3 bit 0 is slot 8).
  function automatic logic [7:0] smi_pin(input int s);
    case (s)
      0, 1, 2: return 8'(s + 8);
      3: return 8'd40;
      4, 5, 6, 7: return 8'(s + 8);
      8, 9, 10, 11: return 8'(s + 8);
      12: return 8'd25;
      13: return 8'd26;
      14: return 8'd27;
      15: return 8'd41;
      16, 17, 18, 19: return 8'(s + 20);
      20: return PIN_TACH1;
      21: return PIN_TACH2;
      default: return PIN_NONE;
    endcase
  endfunction

  // Pin slot behind each either-edge status bit.
  function automatic logic [7:0] misc_pin(input int s);
    case (s)
      0: return 8'd9;
      1: return 8'd10;
      2: return 8'd25;
      3: return 8'd27;
      4: return 8'd40;
      default: return 8'd41;
    endcase
  endfunction

  // Pins that keep waking the system on standby power alone.
  function automatic logic standby_ok(input logic [7:0] p);
    return !(p == 8'd18 || p == 8'd19 || p == 8'd35);
  endfunction

  // Configuration reset value per pin slot.
  function automatic logic [7:0] cfg_rst(input int p);
    return (p == 18 || p == 19 || p == 35) ? CFG_RST_OUT_LOW : CFG_RST_IN;
  endfunction

endpackage

// ===== core/gpw_port.sv
// GPIO port block with direction, polarity, driver type and wake/SMI events.
// Assumes pads resolved outside from pad_o/pad_oe_n and a one-cycle register port.
//
// Function
// R1: Config bit 0 selects input when set; bit 1 inverts the pin value.
// R2: Config bit 7 picks open-drain or push-pull, also for SMI output function.
// R3: Polarity applies in port and alternate use, except listed exception pins.
// R4: Joystick axis alternates drive open-drain non-inverted, ignoring configuration.
// R5: Keyboard port and joystick alternates behave bidirectionally on their pins.
// R6: Input pin read returns synchronised pin level, inverted when polarity set.
// R7: Writing an input pin data bit changes nothing.
// R8: Output pin drives written data, inverted when polarity set.
// R9: Output pin read returns last written value, not pin level.
// R10: Output pins never raise wake or SMI status.
// R11: Wake status sets on rising edge, or falling edge when inverted.
// R12: Wake event needs status, its enable and the global enable.
// R13: Status bits clear only on writing one; zero leaves them.
// R14: Thirty-one wake status and enable bits over banks two to five.
// R15: Nineteen SMI pin bits in banks three to five plus two tach events; the code maps twenty pin bits.
// R16: Either-edge pins set misc, wake and SMI status on both edges.
// R17: Register block sits at the runtime base address from configuration.
// R18: Three pins come out of reset as outputs driving low.
// R19: Drive-rate pin resets to plain port function.
// R20: On standby power only standby-capable pins may raise wake status.
// R21: Software keeps SMI enable off for the pin acting as SMI output.
// R22: Either-edge selection frees the pin; polarity still alters read value.
// R23: Pins pass two flip-flops before edge detection.
// R24: Status bits set whether or not enabled.
//
// Design decisions made here: the address-and-strobe port and the address map.

`timescale 1ns/100ps

module gpw_port (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port.
  input wire gpw_pkg::gpw_bus_req_t bus_req,
  input wire logic [15:0] wake_register_block,
  output logic [7:0] rd_data,
  // Pads.
  input wire logic [47:0] pad_i,
  output logic [47:0] pad_o,
  output logic [47:0] pad_oe_n,
  // Alternate function side.
  input wire logic [47:0] alt_o,
  input wire logic [47:0] alt_oe,
  output logic [47:0] alt_i,
  input wire logic group_smi_out,
  input wire logic fan_tach_one,
  input wire logic fan_tach_two,
  // Power state and events.
  input wire logic standby_mode,
  output logic wake_out,
  output logic smi_event
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [47:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [1:0] tach_s1_q, tach_s2_q, tach_prev_q;
  logic standby_s1_q, standby_s2_q;
  logic [7:0] cfg_q [gpw_pkg::NPIN];
  logic [47:0] data_q;
  logic [31:0] wake_sts_q, wake_en_q, wake_set, wake_clr;
  logic [23:0] smi_sts_q, smi_en_q, smi_set, smi_clr;
  logic [5:0] misc_sts_q, misc_set, misc_clr;
  logic glb_en_q;
  logic [47:0] pad_o_d, pad_oe_n_d, alt_i_d;
  logic [47:0] is_out, either_edge_irq_sel, qual;
  logic [1:0] tach_rise;
  logic [15:0] ofs_full;
  logic [7:0] ofs;
  logic in_win, wake_out_q, smi_event_q;
  logic [7:0] rd_d, rd_q;

  // True when the register offset equals the target inside the block window.
  function automatic logic hit(input logic [7:0] o, input logic w, input logic [7:0] t);
    return w && (o == t);
  endfunction

  // Either-edge capable pins.
  function automatic logic either_edge_irq_cap(input int p);
    return p == 9 || p == 10 || p == 25 || p == 27 || p == 40 || p == 41;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Address window.

  // R17: base relative decode
  assign ofs_full = bus_req.addr - wake_register_block;
  assign in_win = (ofs_full[15:8] == 8'h00);
  assign ofs = ofs_full[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detect.

  // R23: two-stage pin sync
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_q <= 48'h0000_0000_0000;
      pin_s2_q <= 48'h0000_0000_0000;
      pin_prev_q <= 48'h0000_0000_0000;
    end else begin
      pin_s1_q <= pad_i;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Tachometer and standby level synchronisers.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tach_s1_q <= 2'h0;
      tach_s2_q <= 2'h0;
      tach_prev_q <= 2'h0;
      standby_s1_q <= 1'b0;
      standby_s2_q <= 1'b0;
    end else begin
      tach_s1_q <= {fan_tach_two, fan_tach_one};
      tach_s2_q <= tach_s1_q;
      tach_prev_q <= tach_s2_q;
      standby_s1_q <= standby_mode;
      standby_s2_q <= standby_s1_q;
    end
  end

  assign tach_rise = tach_s2_q & ~tach_prev_q;

  // Per-pin mode and qualifying edge.
  always_comb begin
    for (int i = 0; i < gpw_pkg::NPIN; i++) begin
      either_edge_irq_sel[i] = cfg_q[i][gpw_pkg::CFG_EITHER_EDGE_IRQ] && either_edge_irq_cap(i);
      // R1: direction bit
      is_out[i] = !cfg_q[i][gpw_pkg::CFG_DIR] && !either_edge_irq_sel[i];
      if (either_edge_irq_sel[i]) begin
        // R16: both edges count
        qual[i] = pin_s2_q[i] ^ pin_prev_q[i];
      end else if (is_out[i]) begin
        // R10: outputs excluded
        qual[i] = 1'b0;
      end else if (cfg_q[i][gpw_pkg::CFG_POL]) begin
        // R11: inverted falling edge
        qual[i] = !pin_s2_q[i] && pin_prev_q[i];
      end else begin
        qual[i] = pin_s2_q[i] && !pin_prev_q[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and data registers.

  // R18: reset outputs low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < gpw_pkg::NPIN; i++) begin
        // R19: alternate select cleared
        cfg_q[i] <= gpw_pkg::cfg_rst(i);
      end
    end else if (bus_req.wr) begin
      for (int i = 0; i < gpw_pkg::NPIN; i++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_CFG_BASE + i))) begin
          cfg_q[i] <= bus_req.wdata;
        end
      end
    end
  end

  // Data bits store only for pins acting as outputs.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_q <= 48'h0000_0000_0000;
    end else if (bus_req.wr) begin
      for (int k = 0; k < gpw_pkg::NPORT; k++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_DATA_BASE + k))) begin
          for (int b = 0; b < 8; b++) begin
            // R7: input write ignored
            if (is_out[k * 8 + b]) begin
              data_q[k * 8 + b] <= bus_req.wdata[b];
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event sources.

  // R14: wake bit map
  for (genvar s = 0; s < gpw_pkg::NWAKE; s++) begin : g_wake
    localparam logic [7:0] P = gpw_pkg::wake_pin(s);
    if (P == gpw_pkg::PIN_NONE) begin : g_none
      assign wake_set[s] = 1'b0;
    end else begin : g_pin
      localparam logic SB = gpw_pkg::standby_ok(P);
      // R20: standby pin gating
      assign wake_set[s] = qual[P[5:0]] && (!standby_s2_q || SB);
    end
  end

  // R15: SMI bit map
  for (genvar s = 0; s < gpw_pkg::NSMI; s++) begin : g_smi
    localparam logic [7:0] P = gpw_pkg::smi_pin(s);
    if (P == gpw_pkg::PIN_NONE) begin : g_none
      assign smi_set[s] = 1'b0;
    end else if (P == gpw_pkg::PIN_TACH1) begin : g_t1
      assign smi_set[s] = tach_rise[0];
    end else if (P == gpw_pkg::PIN_TACH2) begin : g_t2
      assign smi_set[s] = tach_rise[1];
    end else begin : g_pin
      assign smi_set[s] = qual[P[5:0]];
    end
  end

  // R16: misc either-edge map
  for (genvar s = 0; s < gpw_pkg::NMISC; s++) begin : g_misc
    localparam logic [7:0] P = gpw_pkg::misc_pin(s);
    assign misc_set[s] = qual[P[5:0]] && either_edge_irq_sel[P[5:0]];
  end

  // Write-one clear masks.
  always_comb begin
    wake_clr = 32'h0000_0000;
    smi_clr = 24'h00_0000;
    misc_clr = 6'h00;
    if (bus_req.wr) begin
      for (int r = 0; r < 4; r++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_WAKE_STS + r))) begin
          wake_clr[r * 8 +: 8] = bus_req.wdata;
        end
      end
      for (int r = 0; r < 3; r++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_SMI_STS + r))) begin
          smi_clr[r * 8 +: 8] = bus_req.wdata;
        end
      end
      if (hit(ofs, in_win, gpw_pkg::OFS_MISC_STS)) begin
        misc_clr = bus_req.wdata[5:0];
      end
    end
  end

  // R13: write one clears
  // R24: set ignores enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_sts_q <= 32'h0000_0000;
      smi_sts_q <= 24'h00_0000;
      misc_sts_q <= 6'h00;
    end else begin
      wake_sts_q <= (wake_sts_q & ~wake_clr) | wake_set;
      smi_sts_q <= (smi_sts_q & ~smi_clr) | smi_set;
      misc_sts_q <= (misc_sts_q & ~misc_clr) | misc_set;
    end
  end

  // Enable registers.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_en_q <= 32'h0000_0000;
      smi_en_q <= 24'h00_0000;
      glb_en_q <= 1'b0;
    end else if (bus_req.wr) begin
      for (int r = 0; r < 4; r++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_WAKE_EN + r))) begin
          wake_en_q[r * 8 +: 8] <= bus_req.wdata;
        end
      end
      for (int r = 0; r < 3; r++) begin
        if (hit(ofs, in_win, 8'(gpw_pkg::OFS_SMI_EN + r))) begin
          smi_en_q[r * 8 +: 8] <= bus_req.wdata;
        end
      end
      if (hit(ofs, in_win, gpw_pkg::OFS_WAKE_GLB)) begin
        glb_en_q <= bus_req.wdata[gpw_pkg::GLB_EN_BIT];
      end
    end
  end

  // R12: gated wake level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_out_q <= 1'b0;
      smi_event_q <= 1'b0;
    end else begin
      wake_out_q <= glb_en_q && |(wake_sts_q & wake_en_q);
      smi_event_q <= |(smi_sts_q & smi_en_q);
    end
  end

  assign wake_out = wake_out_q;
  assign smi_event = smi_event_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive.

  // Next pad values from configuration, data and alternate function.
  always_comb begin
    for (int i = 0; i < gpw_pkg::NPIN; i++) begin
      logic val, drv, od;
      // R8: inverted output data
      val = data_q[i] ^ cfg_q[i][gpw_pkg::CFG_POL];
      drv = is_out[i];
      // R2: driver type bit
      od = cfg_q[i][gpw_pkg::CFG_OD];
      if (either_edge_irq_sel[i]) begin
        // R22: pin left as input
        drv = 1'b0;
      end else if (cfg_q[i][gpw_pkg::CFG_ALT]) begin
        if ((i >= gpw_pkg::PIN_JOY_LO && i <= gpw_pkg::PIN_JOY_HI) || i == gpw_pkg::PIN_KBC_A) begin
          // R4: joystick open-drain
          // R5: released high reads back
          val = alt_o[i];
          drv = 1'b1;
          od = 1'b1;
        end else if (i == gpw_pkg::PIN_SMI_OUT) begin
          val = group_smi_out ^ cfg_q[i][gpw_pkg::CFG_POL];
          drv = 1'b1;
        end else if (i == gpw_pkg::PIN_DRIVE_RATE) begin
          // R3: drive-rate no inversion
          val = alt_o[i];
          drv = alt_oe[i];
          od = 1'b0;
        end else begin
          // R3: alternate polarity
          val = alt_o[i] ^ cfg_q[i][gpw_pkg::CFG_POL];
          drv = alt_oe[i];
          od = 1'b0;
        end
      end
      pad_o_d[i] = od ? 1'b0 : val;
      pad_oe_n_d[i] = !(drv && (!od || !val));
      if (either_edge_irq_sel[i] || i == gpw_pkg::PIN_DRIVE_RATE
          || (i >= gpw_pkg::PIN_JOY_LO && i <= gpw_pkg::PIN_JOY_HI)) begin
        alt_i_d[i] = pin_s2_q[i];
      end else begin
        alt_i_d[i] = pin_s2_q[i] ^ cfg_q[i][gpw_pkg::CFG_POL];
      end
    end
  end

  // Registered pad and alternate outputs.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pad_o <= 48'h0000_0000_0000;
      pad_oe_n <= gpw_pkg::PAD_OE_N_RST;
      alt_i <= 48'h0000_0000_0000;
    end else begin
      pad_o <= pad_o_d;
      pad_oe_n <= pad_oe_n_d;
      alt_i <= alt_i_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Read mux over the register window.
  always_comb begin
    rd_d = 8'h00;
    for (int k = 0; k < gpw_pkg::NPORT; k++) begin
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_DATA_BASE + k))) begin
        for (int b = 0; b < 8; b++) begin
          // R6: input read
          // R9: output readback
          rd_d[b] = is_out[k * 8 + b] ? data_q[k * 8 + b]
                  : pin_s2_q[k * 8 + b] ^ cfg_q[k * 8 + b][gpw_pkg::CFG_POL];
        end
      end
    end
    for (int i = 0; i < gpw_pkg::NPIN; i++) begin
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_CFG_BASE + i))) begin
        rd_d = cfg_q[i];
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_WAKE_STS + r))) rd_d = wake_sts_q[r * 8 +: 8];
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_WAKE_EN + r))) rd_d = wake_en_q[r * 8 +: 8];
    end
    for (int r = 0; r < 3; r++) begin
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_SMI_STS + r))) rd_d = smi_sts_q[r * 8 +: 8];
      if (hit(ofs, in_win, 8'(gpw_pkg::OFS_SMI_EN + r))) rd_d = smi_en_q[r * 8 +: 8];
    end
    if (hit(ofs, in_win, gpw_pkg::OFS_WAKE_GLB)) rd_d = {7'h00, glb_en_q};
    if (hit(ofs, in_win, gpw_pkg::OFS_MISC_STS)) rd_d = {2'h0, misc_sts_q};
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= bus_req.rd ? rd_d : 8'h00;
    end
  end

  assign rd_data = rd_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  out_drive_a: assert property (is_out[1] && !cfg_q[1][gpw_pkg::CFG_ALT] // R8
    && !cfg_q[1][gpw_pkg::CFG_OD]
    |=> !pad_oe_n[1] && pad_o[1] == ($past(data_q[1]) ^ $past(cfg_q[1][gpw_pkg::CFG_POL])))
    else $error("output pin not driven with data");
  in_release_a: assert property (cfg_q[0][0] && !cfg_q[0][3] |=> pad_oe_n[0]) // R1
    else $error("input pin driven");
  od_high_a: assert property (is_out[3] && !cfg_q[3][gpw_pkg::CFG_ALT] // R2
    && cfg_q[3][gpw_pkg::CFG_OD] && (data_q[3] ^ cfg_q[3][gpw_pkg::CFG_POL]) |=> pad_oe_n[3])
    else $error("open-drain high not released");
  joy_od_a: assert property (cfg_q[4][3] && alt_o[4] && !either_edge_irq_sel[4] |=> pad_oe_n[4]) // R4
    else $error("joystick pin drives high");
  wake_edge_a: assert property (cfg_q[2][gpw_pkg::CFG_DIR] && !cfg_q[2][gpw_pkg::CFG_POL] // R11
    && pin_s2_q[2] && !pin_prev_q[2] |=> wake_sts_q[2])
    else $error("wake status missed rising edge");
  out_excl_a: assert property (is_out[2] |-> !wake_set[2]) // R10
    else $error("output pin raised wake");
  w1c_zero_a: assert property (bus_req.wr && hit(ofs, in_win, gpw_pkg::OFS_WAKE_STS) // R13
    && bus_req.wdata == 8'h00 |=> (($past(wake_sts_q[7:0]) & ~wake_sts_q[7:0]) == 8'h00))
    else $error("zero write cleared status");
  glb_gate_a: assert property (!glb_en_q |=> !wake_out) // R12
    else $error("wake out without global enable");
  either_edge_irq_both_a: assert property (either_edge_irq_sel[9] && !pin_s2_q[9] && pin_prev_q[9] // R16
    |=> misc_sts_q[0] && wake_sts_q[9] && smi_sts_q[1])
    else $error("either-edge fall not recorded");
  standby_a: assert property (standby_s2_q |-> !wake_set[18]) // R20
    else $error("standby excluded pin raised wake");
  rst_low_a: assert property ($past(sys_rst) |-> !pad_oe_n[18] && !pad_o[18]) // R18
    else $error("pin not low after reset");
  rd_out_a: assert property (bus_req.rd && hit(ofs, in_win, gpw_pkg::OFS_DATA_BASE) // R9
    && is_out[1] |=> rd_data[1] == $past(data_q[1]))
    else $error("output readback wrong");

  wake_c: cover property (glb_en_q && wake_sts_q[2] && wake_en_q[2] ##1 wake_out);
  smi_c: cover property (smi_event);
  either_edge_irq_c: cover property (misc_sts_q[0]);
  joy_c: cover property (cfg_q[4][gpw_pkg::CFG_ALT] && pad_oe_n[4] && alt_i[4]);

endmodule

// ===== test/gpw_board.sv
// Board model for the pads of the GPIO port block.
// Assumes the bench sets the level that the board circuits drive on each pin.
`timescale 1ns/100ps

module gpw_board (
  // Device side of the pads.
  input wire logic [47:0] pad_o,
  input wire logic [47:0] pad_oe_n,
  // Board side drive.
  input wire logic [47:0] drv_val,
  // Resolved pin level.
  output logic [47:0] pad_i
);
  // A pin the device drives shows its value; elsewhere the board level wins.
  assign pad_i = (~pad_oe_n & pad_o) | (pad_oe_n & drv_val);
endmodule

// ===== test/gpw_port_tb_top.sv
// Self-checking bench for the GPIO port block with wake and SMI events.
// Assumes the pad model in gpw_board and the register map of gpw_pkg.
`timescale 1ns/100ps

module gpw_port_tb_top;
  localparam logic [15:0] BASE = 16'h0A00;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  gpw_pkg::gpw_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [47:0] pad_i, pad_o, pad_oe_n, alt_i, drv_val = '0;
  logic [47:0] alt_o = 48'h0000_0000_0000;
  logic fan_tach_one = 1'b0;
  logic fan_tach_two = 1'b0;
  logic group_smi_out = 1'b0;
  logic standby_mode = 1'b0;
  logic wake_out, smi_event;
  logic [15:0] seed = 16'h0010;
  logic [7:0] d, v;
  int num_errors = 0;
  int tests_run = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, design and board.
  always #25 sys_clk = ~sys_clk;

  gpw_port gpw_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .wake_register_block(BASE), .rd_data(rd_data), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_n(pad_oe_n), .alt_o(alt_o), .alt_oe(48'h0), .alt_i(alt_i),
    .group_smi_out(group_smi_out), .fan_tach_one(fan_tach_one), .fan_tach_two(fan_tach_two),
    .standby_mode(standby_mode), .wake_out(wake_out), .smi_event(smi_event));

  gpw_board gpw_board_i (.pad_o(pad_o), .pad_oe_n(pad_oe_n), .drv_val(drv_val),
    .pad_i(pad_i));

  ////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected read of an input pin after polarity.
  function automatic logic [7:0] pin_read(input logic [7:0] pin, input logic [7:0] pol);
    return pin ^ pol;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] off, input logic [7:0] wd);
    @(posedge sys_clk);
    bus_req <= '{1'b1, 1'b0, BASE + off, wd};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [15:0] off, output logic [7:0] rv);
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b1, BASE + off, 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    rv = rd_data;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard.
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(16'h0092, d);
    chk(d, 8'h00);
    chk({6'h00, pad_oe_n[18], pad_o[18]}, 8'h00);
    rd(16'h0080, d);
    chk(d, 8'h01);
    rd(16'h009B, d);
    chk(d, 8'h01);
    // Random input levels, reads and ignored writes.
    for (int i = 0; i < 8; i++) begin
      repeat (7) seed = lfsr(seed);
      v = seed[7:0];
      drv_val[7:0] <= v;
      tick(5);
      rd(16'h004B, d);
      chk(d, pin_read(v, 8'h00));
      wr(16'h004B, ~v);
      rd(16'h004B, d);
      chk(d, v);
    end
    wr(16'h0080, 8'h03);
    tick(5);
    rd(16'h004B, d);
    chk(d, pin_read(v, 8'h01));
    wr(16'h0080, 8'h01);
    // Output pin drives written data, read returns written data.
    wr(16'h0081, 8'h00);
    wr(16'h004B, 8'h02);
    tick(3);
    chk({6'h00, pad_oe_n[1], pad_o[1]}, 8'h01);
    wr(16'h0081, 8'h02);
    tick(3);
    chk({7'h00, pad_o[1]}, 8'h00);
    rd(16'h004B, d);
    chk(d & 8'h02, 8'h02);
    wr(16'h0010, 8'hFF);
    wr(16'h0081, 8'h00);
    tick(6);
    rd(16'h0010, d);
    chk(d & 8'h02, 8'h00);
    // Wake status, enables and write-one clear.
    drv_val[2] <= 1'b0;
    tick(5);
    wr(16'h0010, 8'hFF);
    drv_val[2] <= 1'b1;
    tick(5);
    rd(16'h0010, d);
    chk(d & 8'h04, 8'h04);
    chk({7'h00, wake_out}, 8'h00);
    wr(16'h0014, 8'h04);
    tick(2);
    chk({7'h00, wake_out}, 8'h00);
    wr(16'h0018, 8'h01);
    tick(2);
    chk({7'h00, wake_out}, 8'h01);
    wr(16'h0010, 8'h00);
    rd(16'h0010, d);
    chk(d & 8'h04, 8'h04);
    wr(16'h0010, 8'h04);
    rd(16'h0010, d);
    chk(d & 8'h04, 8'h00);
    // Inverted polarity takes the falling edge only.
    wr(16'h0082, 8'h03);
    tick(5);
    wr(16'h0010, 8'h04);
    drv_val[2] <= 1'b0;
    tick(5);
    rd(16'h0010, d);
    chk(d & 8'h04, 8'h04);
    wr(16'h0010, 8'h04);
    drv_val[2] <= 1'b1;
    tick(5);
    rd(16'h0010, d);
    chk(d & 8'h04, 8'h00);
    chk({7'h00, alt_i[2]}, 8'h00);
    // Standby power keeps only capable pins waking.
    wr(16'h0092, 8'h01);
    drv_val[18] <= 1'b0;
    drv_val[16] <= 1'b0;
    standby_mode <= 1'b1;
    tick(5);
    wr(16'h0012, 8'hFF);
    drv_val[18] <= 1'b1;
    drv_val[16] <= 1'b1;
    tick(5);
    rd(16'h0012, d);
    chk(d & 8'h01, 8'h01);
    chk(d & 8'h04, 8'h00);
    standby_mode <= 1'b0;
    // Either-edge pin sets misc status on both edges; wake status checked on the fall.
    wr(16'h0089, 8'h05);
    drv_val[9] <= 1'b0;
    tick(5);
    wr(16'h0026, 8'hFF);
    drv_val[9] <= 1'b1;
    tick(5);
    rd(16'h0026, d);
    chk(d & 8'h01, 8'h01);
    wr(16'h0026, 8'hFF);
    wr(16'h0011, 8'hFF);
    drv_val[9] <= 1'b0;
    tick(5);
    rd(16'h0026, d);
    chk(d & 8'h01, 8'h01);
    rd(16'h0011, d);
    chk(d & 8'h02, 8'h02);
    // Either-edge pin ignores direction but polarity still flips the read.
    wr(16'h0089, 8'h06);
    tick(3);
    rd(16'h004C, d);
    chk(d & 8'h02, 8'h02);
    chk({7'h00, pad_oe_n[9]}, 8'h01);
    // Open-drain output releases the pad for a one.
    wr(16'h0083, 8'h80);
    wr(16'h004B, 8'h08);
    tick(3);
    chk({7'h00, pad_oe_n[3]}, 8'h01);
    wr(16'h004B, 8'h00);
    tick(3);
    chk({6'h00, pad_oe_n[3], pad_o[3]}, 8'h00);
    // Joystick axis alternate drives open-drain and reads back uninverted.
    wr(16'h0084, 8'h0A);
    tick(3);
    chk({6'h00, pad_oe_n[4], pad_o[4]}, 8'h00);
    alt_o[4] <= 1'b1;
    drv_val[4] <= 1'b1;
    tick(5);
    chk({7'h00, pad_oe_n[4]}, 8'h01);
    chk({7'h00, alt_i[4]}, 8'h01);
    // Group SMI output alternate follows the driver type bit.
    // its SMI enable stays clear.
    wr(16'h008F, 8'h88);
    group_smi_out <= 1'b1;
    tick(3);
    chk({7'h00, pad_oe_n[15]}, 8'h01);
    group_smi_out <= 1'b0;
    tick(3);
    chk({6'h00, pad_oe_n[15], pad_o[15]}, 8'h00);
    // Tachometer events and SMI output.
    fan_tach_one <= 1'b1;
    fan_tach_two <= 1'b1;
    tick(5);
    rd(16'h0022, d);
    chk(d & 8'h30, 8'h30);
    wr(16'h0025, 8'h10);
    tick(2);
    chk({7'h00, smi_event}, 8'h01);
    // Unmapped offset and an address below the block base.
    rd(16'h0030, d);
    chk(d, 8'h00);
    rd(16'hFFFF, d);
    chk(d, 8'h00);
    test_done();
  end
endmodule
